// ==== rtl/plg_pkg.sv ====
// constants and carrier types for the scan-evaluated basic logic elements
// assumes a 32-bit apb slave port and one scan enable per scan cycle
package plg_pkg;

   // element indices
   localparam int EL_AND = 0;
   localparam int EL_AND_EDGE = 1;
   localparam int EL_NAND = 2;
   localparam int EL_NAND_EDGE = 3;
   localparam int EL_OR = 4;
   localparam int EL_NOR = 5;
   localparam int EL_XOR = 6;
   localparam int EL_NOT = 7;
   localparam int EL_BOOL = 8;
   localparam int NUM_EL = 9;
   localparam int NUM_IN = 4;

   // level given to an unconnected input, one bit per element
   localparam logic [NUM_EL-1:0] IDLE_HIGH = 9'h00f;

   // register byte addresses
   localparam logic [7:0] ADDR_CFG_BASE = 8'h00;
   localparam logic [7:0] ADDR_TABLE = 8'h24;
   localparam logic [7:0] ADDR_CTRL = 8'h28;
   localparam logic [7:0] ADDR_STATUS = 8'h2c;
   localparam logic [7:0] ADDR_DIV = 8'h30;

   // field positions
   localparam int CFG_CONN_LSB = 0;
   localparam int CFG_INV_LSB = 4;
   localparam int TABLE_POL_BIT = 16;
   localparam int CTRL_RUN_BIT = 0;

   // reset values
   localparam logic [3:0] CONN_RESET = 4'hf;
   localparam logic [3:0] INV_RESET = 4'h0;
   localparam logic [15:0] TABLE_RESET = 16'h0000;
   localparam logic CTRL_RUN_RESET = 1'b1;

   // timing: one scan cycle, in ns, and its length in clock cycles
   localparam int CLK_PERIOD_NS = 5;
   localparam int SCAN_PERIOD_NS = 1000;
   localparam int SCAN_CYCLES = (SCAN_PERIOD_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

   // per-element input configuration
   typedef struct packed {
      logic [NUM_IN-1:0] invert;
      logic [NUM_IN-1:0] connect;
   } plg_cfg_t;

   // truth-table element configuration
   typedef struct packed {
      logic invert_out;
      logic [15:0] table_bits;
   } plg_table_t;

endpackage : plg_pkg

// ==== rtl/plg_cond.sv ====
// input conditioning for one logic element: inversion and unconnected level
// assumes purely combinational use inside the scan-evaluated top
`timescale 1ns/1ps
`default_nettype none

module plg_cond #(
   parameter logic IDLE_LEVEL = 1'b0
) (
   // raw levels from other blocks
   input wire logic [plg_pkg::NUM_IN-1:0] raw,
   // configuration
   input wire plg_pkg::plg_cfg_t cfg,
   // conditioned levels
   output logic [plg_pkg::NUM_IN-1:0] cond
);

   genvar i;
   generate
      for (i = 0; i < plg_pkg::NUM_IN; i++)
      begin : g_bit
         // per-input inversion, then unconnected level
         // inversion before evaluation
         assign cond[i] = cfg.connect[i] ? (raw[i] ^ cfg.invert[i])
                                         : IDLE_LEVEL;
      end
   endgenerate

endmodule : plg_cond

`default_nettype wire

// ==== rtl/plg_gates.sv ====
// basic logic elements evaluated once per scan, with apb configuration
// assumes apb master keeps request stable until pready; inputs synchronous
`timescale 1ns/1ps
`default_nettype none

//Contract
//- plain and output high only when all four inputs are high
//- unconnected plain and inputs read as high
//- edge and fires when all high and some input was low before
//- edge and pulse lasts one scan, then low at least one scan
//- unconnected edge and, nand, edge nand inputs read as high
//- plain nand output low only when all four inputs are high
//- edge nand fires when some input low and all were high before
//- edge nand pulse lasts one scan, then low at least one scan
//- or output high when any of four inputs is high
//- unconnected or, nor, xor inputs read as low
//- nor output high only when all four inputs are low
//- two-input xor high when its inputs differ
//- not output is the inverse of its single input
//- truth-table element holds one output bit per input combination
//- unconnected truth-table inputs are forced low
//- truth-table polarity option outputs entry or its complement
//- every element input has its own inversion before evaluation
module plg_gates #(
   parameter int SCAN_DIV = plg_pkg::SCAN_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // element inputs, element e uses bits 4e+3..4e, input one at 4e+3
   input wire logic [plg_pkg::NUM_EL*plg_pkg::NUM_IN-1:0] gate_in,
   // element outputs, one per element
   output logic [plg_pkg::NUM_EL-1:0] gate_out,
   // one-cycle pulse each time a scan is evaluated
   output logic scan_done
);

   localparam int NE = plg_pkg::NUM_EL;
   localparam int NI = plg_pkg::NUM_IN;

   plg_pkg::plg_cfg_t cfg [NE];
   plg_pkg::plg_table_t tbl;
   logic run;
   logic [15:0] div_reload;
   logic [15:0] div_cnt;
   logic scan_tick;
   logic [NI-1:0] cond [NE];
   logic [NI-1:0] prev_and_edge;
   logic [NI-1:0] prev_nand_edge;
   logic [NE-1:0] next_out;
   logic apb_access;
   logic apb_write;
   logic cfg_hit;
   logic [3:0] cfg_idx;
   logic [7:0] cfg_off;
   logic mapped;
   logic [31:0] next_rdata;

   // input conditioning, one instance per element
   genvar e;
   generate
      for (e = 0; e < NE; e++)
      begin : g_el
         plg_cond #(
            .IDLE_LEVEL(plg_pkg::IDLE_HIGH[e])
         ) u_cond (
            .raw(gate_in[e*NI +: NI]),
            .cfg(cfg[e]),
            .cond(cond[e])
         );
      end
   endgenerate

   // apb decode
   assign apb_access = psel & penable & ~pready;
   assign apb_write = psel & penable & pready & pwrite;
   // offset from the block base so the base can move without a remap
   assign cfg_off = paddr - plg_pkg::ADDR_CFG_BASE;
   assign cfg_idx = cfg_off[5:2];
   assign cfg_hit = (paddr[1:0] == 2'h0) && (cfg_off < 8'(4 * NE));

   always_comb
   begin
      mapped = 1'b1;
      next_rdata = 32'h0000_0000;
      if (cfg_hit)
      begin
         next_rdata[plg_pkg::CFG_CONN_LSB +: NI] = cfg[cfg_idx].connect;
         next_rdata[plg_pkg::CFG_INV_LSB +: NI] = cfg[cfg_idx].invert;
      end
      else
      begin
         case (paddr)
            plg_pkg::ADDR_TABLE:
            begin
               next_rdata[15:0] = tbl.table_bits;
               next_rdata[plg_pkg::TABLE_POL_BIT] = tbl.invert_out;
            end
            plg_pkg::ADDR_CTRL:
               next_rdata[plg_pkg::CTRL_RUN_BIT] = run;
            plg_pkg::ADDR_STATUS:
               next_rdata[NE-1:0] = gate_out;
            plg_pkg::ADDR_DIV:
               next_rdata[15:0] = div_reload;
            default:
               mapped = 1'b0;
         endcase
      end
   end

   // apb answer: one wait state, data and error registered
   // prdata falls back to zero so a stale read never lingers on the bus
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= apb_access;
         if (apb_access)
         begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= ~mapped;
         end
         else
         begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
      end
   end

   // element configuration registers
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < NE; i++)
         begin
            cfg[i].connect <= plg_pkg::CONN_RESET;
            cfg[i].invert <= plg_pkg::INV_RESET;
         end
      end
      else if (apb_write && cfg_hit)
      begin
         cfg[cfg_idx].connect <= pwdata[plg_pkg::CFG_CONN_LSB +: NI];
         cfg[cfg_idx].invert <= pwdata[plg_pkg::CFG_INV_LSB +: NI];
      end
   end

   // truth table, polarity, run and scan divider registers
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tbl.table_bits <= plg_pkg::TABLE_RESET;
         tbl.invert_out <= 1'b0;
         run <= plg_pkg::CTRL_RUN_RESET;
         div_reload <= 16'(SCAN_DIV - 1);
      end
      else if (apb_write && !cfg_hit)
      begin
         case (paddr)
            plg_pkg::ADDR_TABLE:
            begin
               tbl.table_bits <= pwdata[15:0];
               tbl.invert_out <= pwdata[plg_pkg::TABLE_POL_BIT];
            end
            plg_pkg::ADDR_CTRL:
               run <= pwdata[plg_pkg::CTRL_RUN_BIT];
            plg_pkg::ADDR_DIV:
               div_reload <= pwdata[15:0];
            default:
               run <= run;
         endcase
      end
   end

   // scan divider; a stopped scan freezes outputs and history
   // common scan enable
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         div_cnt <= 16'h0000;
         scan_tick <= 1'b0;
      end
      else if (!run)
      begin
         div_cnt <= 16'h0000;
         scan_tick <= 1'b0;
      end
      // >= so a smaller reload takes effect without a full wrap
      else if (div_cnt >= div_reload)
      begin
         div_cnt <= 16'h0000;
         scan_tick <= 1'b1;
      end
      else
      begin
         div_cnt <= div_cnt + 16'h0001;
         scan_tick <= 1'b0;
      end
   end

   // element functions
   always_comb
   begin
      next_out = '0;
      next_out[plg_pkg::EL_AND] = &cond[plg_pkg::EL_AND];
      // second scan sees history all high, so pulse ends
      next_out[plg_pkg::EL_AND_EDGE] = (&cond[plg_pkg::EL_AND_EDGE]) &
                                       ~(&prev_and_edge);
      next_out[plg_pkg::EL_NAND] = ~(&cond[plg_pkg::EL_NAND]);
      // history no longer all high, so pulse ends
      next_out[plg_pkg::EL_NAND_EDGE] = ~(&cond[plg_pkg::EL_NAND_EDGE]) &
                                        (&prev_nand_edge);
      next_out[plg_pkg::EL_OR] = |cond[plg_pkg::EL_OR];
      next_out[plg_pkg::EL_NOR] = ~(|cond[plg_pkg::EL_NOR]);
      next_out[plg_pkg::EL_XOR] = cond[plg_pkg::EL_XOR][3] ^
                                  cond[plg_pkg::EL_XOR][2];
      next_out[plg_pkg::EL_NOT] = ~cond[plg_pkg::EL_NOT][3];
      next_out[plg_pkg::EL_BOOL] =
         tbl.table_bits[cond[plg_pkg::EL_BOOL]] ^ tbl.invert_out;
   end

   // outputs load only on the scan enable and hold in between
   // common scan enable
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         gate_out <= '0;
      end
      else if (scan_tick)
      begin
         gate_out <= next_out;
      end
   end

   // history loads with the outputs, so an edge pulse ends next scan
   // history of the previous scan
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prev_and_edge <= 4'h0;
         prev_nand_edge <= 4'h0;
      end
      else if (scan_tick)
      begin
         prev_and_edge <= cond[plg_pkg::EL_AND_EDGE];
         prev_nand_edge <= cond[plg_pkg::EL_NAND_EDGE];
      end
   end

   // new outputs first stand in the cycle this pulse is high
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scan_done <= 1'b0;
      end
      else
      begin
         scan_done <= scan_tick;
      end
   end

endmodule : plg_gates

`default_nettype wire

// ==== bench/plg_gates_sva.sv ====
// checker for the scan-evaluated logic elements
// assumes a bind onto plg_gates from the bench top
`timescale 1ns/1ps
`default_nettype none
module plg_gates_sva (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // elements
   input wire logic [plg_pkg::NUM_EL-1:0] gate_out,
   input wire logic scan_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_ready_timing: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == '0)
      else $error("prdata not zero outside read answer");
   a_status_view: assert property (pready && !pwrite
      && paddr == plg_pkg::ADDR_STATUS |-> prdata[8:0] == $past(gate_out))
      else $error("status differs from outputs");
   a_out_hold: assert property (!scan_done |-> $stable(gate_out))
      else $error("outputs moved outside a scan");
   a_and_edge_gap: assert property (scan_done && $past(gate_out[1])
      |-> !gate_out[1])
      else $error("and edge pulse lasted two scans");
   a_nand_edge_gap: assert property (scan_done && $past(gate_out[3])
      |-> !gate_out[3])
      else $error("nand edge pulse lasted two scans");
   c_and_edge: cover property (scan_done && gate_out[1]);
   c_nand_edge: cover property (scan_done && gate_out[3]);
   c_refused: cover property (pslverr);
endmodule : plg_gates_sva
`default_nettype wire

// ==== bench/plg_src.sv ====
// model of the blocks and controller inputs feeding the elements
// assumes the bench sets want just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module plg_src (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // levels the feeding blocks should present
   input wire logic [plg_pkg::NUM_EL*plg_pkg::NUM_IN-1:0] want,
   // element inputs
   output logic [plg_pkg::NUM_EL*plg_pkg::NUM_IN-1:0] gate_in
);
   // feeding blocks are registered too, so levels move only on clock edges
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         gate_in <= '0;
      else
         gate_in <= want;
endmodule : plg_src
`default_nettype wire

// ==== bench/tb_plg_basic_logic_gates.sv ====
// self-checking bench for the basic logic elements
// assumes plg_gates, plg_src and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_plg_basic_logic_gates;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [35:0] want = '0;
   logic [35:0] gate_in;
   logic [8:0] gate_out;
   logic scan_done;
   logic [31:0] rdata;
   logic err;
   int gap = 0;
   // each row: nibble on every element, then the outputs it should give;
   // edge outputs follow from the row before, table 6c3a, true polarity
   logic [12:0] rows [20] = '{
      {4'h0, 9'h0a4}, {4'h1, 9'h194}, {4'h2, 9'h094}, {4'h3, 9'h194},
      {4'h4, 9'h1d4}, {4'h5, 9'h1d4}, {4'h6, 9'h0d4}, {4'h7, 9'h0d4},
      {4'h8, 9'h054}, {4'h9, 9'h054}, {4'ha, 9'h154}, {4'hb, 9'h154},
      {4'hc, 9'h014}, {4'hd, 9'h114}, {4'he, 9'h114}, {4'hf, 9'h013},
      {4'hf, 9'h011}, {4'h0, 9'h0ac}, {4'hf, 9'h013}, {4'h7, 9'h0dc}
   };
   int checks = 0;
   int bad_count = 0;
   always #2.5 clk = ~clk;
   // small divider keeps a scan at four clocks
   plg_gates #(.SCAN_DIV(4)) i_dut (.clk(clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .gate_in(gate_in), .gate_out(gate_out), .scan_done(scan_done));
   plg_src i_src (.clk(clk), .resetn(resetn), .want(want),
      .gate_in(gate_in));
   task automatic end_sim();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20)
         bad_count++;
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic e_err);
      apb(1'b0, a, '0);
      chk(rdata, e);
      chk({31'h0, err}, {31'h0, e_err});
   endtask : rd
   task automatic wait_scan();
      int n;
      n = 0;
      do @(posedge clk); while (scan_done !== 1'b1 && ++n < 50);
      if (n >= 50)
         bad_count++;
   endtask : wait_scan
   initial
   begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h00, 32'h0000_000f, 1'b0);
      rd(8'h20, 32'h0000_000f, 1'b0);
      rd(plg_pkg::ADDR_TABLE, 32'h0000_0000, 1'b0);
      rd(plg_pkg::ADDR_CTRL, 32'h0000_0001, 1'b0);
      rd(8'h34, 32'h0000_0000, 1'b1);
      rd(8'h02, 32'h0000_0000, 1'b1);
      apb(1'b1, plg_pkg::ADDR_TABLE, 32'h0000_6c3a);
      wait_scan();
      for (int i = 0; i < 20; i++)
      begin
         want <= {9{rows[i][12:9]}};
         wait_scan();
         chk(32'(gate_out), 32'(rows[i][8:0]));
         chk(32'(gate_out[8]), 32'(rows[i][8]));
         chk(32'(gate_out[7:6]), 32'(rows[i][7:6]));
         chk(32'(gate_out[5:4]), 32'(rows[i][5:4]));
      end
      apb(1'b1, 8'h00, 32'h0000_0003);
      apb(1'b1, 8'h10, 32'h0000_0003);
      apb(1'b1, 8'h18, 32'h0000_004f);
      apb(1'b1, 8'h1c, 32'h0000_008f);
      apb(1'b1, 8'h20, 32'h0000_0001);
      apb(1'b1, plg_pkg::ADDR_TABLE, 32'h0001_6c3a);
      want <= {4'he, 4'h8, 4'h0, 4'h0, 4'hc, 4'h0, 4'h0, 4'h0, 4'h3};
      wait_scan();
      wait_scan();
      chk(32'(gate_out), 32'h0000_01e5);
      apb(1'b1, plg_pkg::ADDR_STATUS, 32'h0000_0000);
      rd(plg_pkg::ADDR_STATUS, 32'h0000_01e5, 1'b0);
      apb(1'b1, plg_pkg::ADDR_CTRL, 32'h0000_0000);
      want <= '1;
      repeat (20) @(posedge clk);
      chk(32'(gate_out), 32'h0000_01e5);
      chk(32'(scan_done), 32'h0000_0000);
      // reset held over several edges so history checks restart cleanly
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'(gate_out), 32'h0000_0000);
      chk(32'({pready, pslverr, scan_done}), 32'h0000_0000);
      chk(prdata, 32'h0000_0000);
      resetn <= 1'b1;
      rd(plg_pkg::ADDR_CTRL, 32'h0000_0001, 1'b0);
      rd(plg_pkg::ADDR_DIV, 32'h0000_0003, 1'b0);
      // a reload of one gives a scan every second clock
      apb(1'b1, plg_pkg::ADDR_DIV, 32'h0000_0001);
      rd(plg_pkg::ADDR_DIV, 32'h0000_0001, 1'b0);
      wait_scan();
      gap = 0;
      do
      begin
         @(posedge clk);
         gap++;
      end
      while (scan_done !== 1'b1 && gap < 50);
      chk(32'(gap), 32'h0000_0002);
      end_sim();
   end
   initial
   begin
      #100_000;
      bad_count++;
      end_sim();
   end
endmodule : tb_plg_basic_logic_gates
bind plg_gates plg_gates_sva i_sva (.clk(clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .gate_out(gate_out), .scan_done(scan_done));
`default_nettype wire
